// ### core/exec_alu.sv
// package of shared constants, and the add and bit-operation datapath
package exec_pkg;
  // instruction word layout
  localparam int INSTR_W      = 14;
  localparam int FADDR_W      = 7;
  localparam int FILE_DEPTH   = 128;
  localparam int DEST_BIT     = 7;
  localparam int BIDX_LSB     = 7;
  localparam int BIDX_W       = 3;
  localparam logic [5:0] OP_ADD_ACC_TO_REG   = 6'h07;
  localparam logic [3:0] OP_CLEAR_REG_BIT    = 4'h4;
  localparam logic [3:0] OP_SET_REG_BIT      = 4'h5;
  localparam logic [3:0] OP_SKIP_IF_BIT_LOW  = 4'h6;
  // flag positions in the flags register
  localparam int FLAG_CARRY   = 0;
  localparam int FLAG_HALF    = 1;
  localparam int FLAG_ZERO    = 2;
  // avalon register map, byte addresses
  localparam int ADDR_W       = 10;
  localparam logic [9:0] REG_CTRL      = 10'h000;
  localparam logic [9:0] REG_ACC       = 10'h004;
  localparam logic [9:0] REG_FLAGS     = 10'h008;
  localparam logic [9:0] REG_EXEC_STAT = 10'h00C;
  localparam logic [9:0] REG_FILE_BASE = 10'h200;
  localparam int CTRL_RUN     = 0;
  // values after reset
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic [2:0] FLAGS_RESET   = 3'h0;
  localparam logic       RUN_RESET     = 1'b0;
  localparam logic [7:0] FILE_RESET    = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_ADD,
    OP_BITCLR,
    OP_BITSET
  } alu_op_t;
endpackage

`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  input  wire alu_op_t    op,         // operation to carry out
  input  wire logic [7:0] acc,        // accumulator operand
  input  wire logic [7:0] freg,       // file register operand
  input  wire logic [2:0] bit_idx,    // bit selected by bit operations
  output logic      [7:0] result,     // operation result
  output logic            carry,      // carry out of bit 7
  output logic            half_carry, // carry out of bit 3
  output logic            zero        // result is zero
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  // a full adder and a low-nibble adder serve the add; bit ops only touch the selected bit
  always_comb begin
    sum        = {1'b0, acc} + {1'b0, freg};
    low_sum    = {1'b0, acc[3:0]} + {1'b0, freg[3:0]};
    carry      = sum[8];
    half_carry = low_sum[4];
    case (op)
      OP_ADD:    result = sum[7:0];
      OP_BITCLR: result = freg & ~(8'h01 << bit_idx);
      OP_BITSET: result = freg | (8'h01 << bit_idx);
      default:   result = freg;
    endcase
    zero = (result == 8'h00);
  end
endmodule

// ### core/bit_and_add_instruction_exec.sv
// executes add, bit clear, bit set and bit-test-skip instructions
// Summary of operation
// - add accumulator and file register; update carry, half carry and zero
// - destination bit zero: result to accumulator, file register untouched
// - destination bit one: result back into the file register
// - clear selected bit of file register, flags untouched, one cycle
// - set selected bit of file register, flags untouched, one cycle
// - test selected bit; skip next instruction only if clear; no flags
// - on skip, discard the prefetched word and run an idle slot instead
// - test takes one cycle, two when skipping; add always one cycle
`timescale 1ns/1ps
module bit_and_add_instruction_exec
  import exec_pkg::*;
(
  input  wire logic               core_clk,         // core clock, 125 MHz
  input  wire logic               rst,              // synchronous reset, active high
  input  wire logic [INSTR_W-1:0] instr_word,       // instruction from program memory
  input  wire logic               instr_valid,      // instruction word present
  output logic                    instr_ready,      // core takes a word this cycle
  output logic                    retired,          // pulse: instruction executed
  output logic                    idle_slot,        // pulse: word discarded by a skip
  input  wire logic [ADDR_W-1:0]  avs_address,      // avalon byte address
  input  wire logic               avs_read,         // avalon read
  input  wire logic               avs_write,        // avalon write
  input  wire logic [3:0]         avs_byteenable,   // avalon byte lanes
  input  wire logic [31:0]        avs_writedata,    // avalon write data
  output logic      [31:0]        avs_readdata,     // avalon read data
  output logic                    avs_waitrequest   // avalon wait, low for one cycle
);
  logic [7:0]           acc;
  logic [2:0]           flags;
  logic                 run;
  logic                 skip_pending;
  logic [7:0]           file_mem [FILE_DEPTH];
  logic                 take;
  logic                 bus_ack;
  logic                 bus_wr;
  logic [FADDR_W-1:0]   faddr;
  logic [2:0]           bit_idx;
  logic                 to_reg;
  logic                 is_add;
  logic                 is_clr;
  logic                 is_set;
  logic                 is_tst;
  logic                 discard;
  logic                 exec_file_wr;
  logic                 next_ready;
  alu_op_t              op;
  logic [7:0]           freg;
  logic [7:0]           result;
  logic                 carry;
  logic                 half_carry;
  logic                 zero;

  // true when the address hits the file register window
  function automatic logic in_file_window(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1] && (a[1:0] == 2'b00);
  endfunction

  // file register index of a window address
  function automatic logic [FADDR_W-1:0] file_index(input logic [ADDR_W-1:0] a);
    return a[FADDR_W+1:2];
  endfunction

  // field split of the instruction word
  assign faddr   = instr_word[FADDR_W-1:0];
  assign bit_idx = instr_word[BIDX_LSB +: BIDX_W];
  assign to_reg  = instr_word[DEST_BIT];
  assign is_add  = (instr_word[13:8] == OP_ADD_ACC_TO_REG);
  assign is_clr  = (instr_word[13:10] == OP_CLEAR_REG_BIT);
  assign is_set  = (instr_word[13:10] == OP_SET_REG_BIT);
  assign is_tst  = (instr_word[13:10] == OP_SKIP_IF_BIT_LOW);

  // a word is consumed when offered and the core is ready for it
  assign take    = instr_valid && instr_ready;
  assign discard = take && skip_pending;
  assign freg    = file_mem[faddr];

  // bus acknowledge cycle is the one with waitrequest low
  assign bus_ack = (avs_read || avs_write) && !avs_waitrequest;
  assign bus_wr  = avs_write && !avs_waitrequest && avs_byteenable[0];

  // choose the datapath operation from the decoded word
  always_comb begin
    if (is_add) begin
      op = OP_ADD;
    end else if (is_clr) begin
      op = OP_BITCLR;
    end else if (is_set) begin
      op = OP_BITSET;
    end else begin
      op = OP_NONE;
    end
  end

  exec_alu u_alu (
    .op         (op),
    .acc        (acc),
    .freg       (freg),
    .bit_idx    (bit_idx),
    .result     (result),
    .carry      (carry),
    .half_carry (half_carry),
    .zero       (zero)
  );

  // file registers written by the executing instruction this cycle
  assign exec_file_wr = take && !skip_pending &&
                        ((is_add && to_reg) || is_clr || is_set);

  // stall the core in the bus acknowledge cycle so both never write at once
  assign next_ready = run && !((avs_read || avs_write) && avs_waitrequest);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      instr_ready <= 1'b0;
    end else begin
      instr_ready <= next_ready;
    end
  end

  // accumulator: add with destination zero, or a bus write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= ACC_RESET;
    end else if (take && !skip_pending && is_add && !to_reg) begin
      acc <= result;
    end else if (bus_wr && avs_address == REG_ACC) begin
      acc <= avs_writedata[7:0];
    end
  end

  // flags change only on the add or a bus write; bit ops and the test leave them alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else if (take && !skip_pending && is_add) begin
      flags[FLAG_CARRY] <= carry;
      flags[FLAG_HALF]  <= half_carry;
      flags[FLAG_ZERO]  <= zero;
    end else if (bus_wr && avs_address == REG_FLAGS) begin
      flags <= avs_writedata[2:0];
    end
  end

  // file register array; the execution path and the bus never share a cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RESET;
      end
    end else if (exec_file_wr) begin
      file_mem[faddr] <= result;
    end else if (bus_wr && in_file_window(avs_address)) begin
      file_mem[file_index(avs_address)] <= avs_writedata[7:0];
    end
  end

  // skip state: the test arms it, the next taken word is dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_pending <= 1'b0;
    end else if (discard) begin
      skip_pending <= 1'b0;
    end else if (take && is_tst) begin
      skip_pending <= !freg[bit_idx];
    end
  end

  // completion pulses; a discarded word counts as the idle second cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      retired   <= 1'b0;
      idle_slot <= 1'b0;
    end else begin
      retired   <= take && !skip_pending;
      idle_slot <= discard;
    end
  end

  // run control; clearing it freezes fetch but keeps a pending skip armed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run <= RUN_RESET;
    end else if (bus_wr && avs_address == REG_CTRL) begin
      run <= avs_writedata[CTRL_RUN];
    end
  end

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_ack) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_read || avs_write);
    end
  end

  // read data captured while waitrequest is high; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      if (avs_address == REG_CTRL) begin
        avs_readdata <= {31'h00000000, run};
      end else if (avs_address == REG_ACC) begin
        avs_readdata <= {24'h000000, acc};
      end else if (avs_address == REG_FLAGS) begin
        avs_readdata <= {29'h00000000, flags};
      end else if (avs_address == REG_EXEC_STAT) begin
        avs_readdata <= {30'h00000000, instr_ready, skip_pending};
      end else if (in_file_window(avs_address)) begin
        avs_readdata <= {24'h000000, file_mem[file_index(avs_address)]};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end
endmodule

// ### tb/prog_mem.sv
// program memory model feeding words to the core
`timescale 1ns/1ps
module prog_mem
  import exec_pkg::*;
(
  input  wire logic               core_clk,    // clock
  input  wire logic               go,          // low rewinds
  input  wire logic [4:0]         len,         // word count
  input  wire logic [INSTR_W-1:0] rom [16],    // image
  input  wire logic               instr_ready, // taken
  output logic      [INSTR_W-1:0] instr_word,  // word
  output logic                    instr_valid  // present
);
  logic [4:0] ptr;
  // advance only when taken, so a stall holds the word
  always_ff @(posedge core_clk) begin
    if (!go) begin
      ptr <= 5'h00;
    end else if (instr_valid && instr_ready) begin
      ptr <= ptr + 5'h01;
    end
  end
  assign instr_valid = go && (ptr < len);
  // no word: show the inverse so stale data never passes
  assign instr_word = instr_valid ? rom[ptr[3:0]] : ~rom[ptr[3:0]];
endmodule

// ### tb/exec_assertions.sv
// port checks for the instruction core
`timescale 1ns/1ps
module exec_checker
  import exec_pkg::*;
(
  input wire logic               core_clk,       // clock
  input wire logic               rst,            // reset
  input wire logic [INSTR_W-1:0] instr_word,     // word
  input wire logic               instr_valid,    // present
  input wire logic               instr_ready,    // taken
  input wire logic               retired,        // done
  input wire logic               idle_slot,      // discard
  input wire logic               avs_read,       // read
  input wire logic               avs_write,      // write
  input wire logic               avs_waitrequest // wait
);
  logic [INSTR_W-1:0] prev_w;
  logic [INSTR_W-1:0] last_w;
  logic               take;
  logic               req;
  assign take = instr_valid && instr_ready;
  assign req = (avs_read || avs_write) && avs_waitrequest;
  // two latest taken words, to see what caused a discard
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_w <= '0;
      last_w <= '0;
    end else if (take) begin
      prev_w <= last_w;
      last_w <= instr_word;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_take_one_pulse: assert property (take |=> retired != idle_slot)
    else $error("taken word gave no single pulse");
  a_no_stray_pulse: assert property (!take |=> !retired && !idle_slot)
    else $error("pulse without a taken word");
  a_idle_after_skip: assert property (idle_slot |-> prev_w[13:10] == OP_SKIP_IF_BIT_LOW)
    else $error("discard not caused by a bit test");
  a_idle_only_once: assert property (idle_slot |=> !idle_slot)
    else $error("two discards in a row");
  a_bus_one_wait: assert property (req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_drops_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_bus_stalls_core: assert property (req |=> !instr_ready)
    else $error("core took word in bus ack cycle");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !instr_ready && !retired)
    else $error("core active in reset");
  c_skip: cover property (take && instr_word[13:10] == OP_SKIP_IF_BIT_LOW);
  c_idle: cover property (idle_slot);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind bit_and_add_instruction_exec exec_checker u_chk (.core_clk, .rst, .instr_word,
  .instr_valid, .instr_ready, .retired, .idle_slot, .avs_read, .avs_write, .avs_waitrequest);

// ### tb/testbench.sv
// self-checking bench for the add and bit core
`timescale 1ns/1ps
module testbench;
  import exec_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               go = 1'b0;
  logic [4:0]         len = 5'h10;
  logic [INSTR_W-1:0] rom [16];
  logic [INSTR_W-1:0] instr_word;
  logic               instr_valid, instr_ready, retired, idle_slot, avs_waitrequest;
  logic [9:0]         avs_address = 10'h000;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0]         fm [128];
  logic [7:0]         acc_m;
  logic [2:0]         flg_m = 3'h0;
  logic               skip_m = 1'b0;
  logic [3:0]         avs_byteenable = 4'hF;
  int                 miscompares = 0, n_tests = 0, nret = 0, nidle = 0, cyc = 0;
  bit_and_add_instruction_exec u_dut (.core_clk, .rst, .instr_word, .instr_valid,
    .instr_ready, .retired, .idle_slot, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest);
  prog_mem u_mem (.core_clk, .go, .len, .rom, .instr_ready, .instr_word, .instr_valid);
  always #4 core_clk = ~core_clk;
  // count pulses; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (retired === 1'b1) nret++;
    if (idle_slot === 1'b1) nidle++;
    if (cyc == 10000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; a free edge after release keeps back to back legal
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [10:0] add_ref(input logic [7:0] a, input logic [7:0] f);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, f};
    return {s[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, f[3:0]}) > 5'h0F, s};
  endfunction
  function automatic logic [INSTR_W-1:0] rnd_word();
    logic [6:0] f;
    f = 7'($urandom) & 7'h47; // few registers, so hazards recur
    case ($urandom % 4)
      0: return {OP_ADD_ACC_TO_REG, 1'($urandom), f};
      1: return {OP_CLEAR_REG_BIT, 3'($urandom), f};
      2: return {OP_SET_REG_BIT, 3'($urandom), f};
      default: return {OP_SKIP_IF_BIT_LOW, 3'($urandom), f};
    endcase
  endfunction
  // reference execution of the loaded program; a skip armed by the last
  // word of a round stays armed while run is off and drops the next round's first word
  task automatic model(output int er, output int ei);
    logic [INSTR_W-1:0] w;
    logic [10:0]        r;
    er = 0;
    ei = 0;
    for (int i = 0; i < 16; i++) begin
      w = rom[i];
      r = add_ref(acc_m, fm[w[6:0]]);
      if (skip_m) begin
        ei++;
        skip_m = 1'b0;
      end else begin
        er++;
        case (w[13:10])
          OP_CLEAR_REG_BIT: fm[w[6:0]][w[9:7]] = 1'b0;
          OP_SET_REG_BIT: fm[w[6:0]][w[9:7]] = 1'b1;
          OP_SKIP_IF_BIT_LOW: skip_m = !fm[w[6:0]][w[9:7]];
          default: begin
            flg_m = r[10:8];
            if (w[7]) fm[w[6:0]] = r[7:0];
            else acc_m = r[7:0];
          end
        endcase
      end
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    logic [9:0]         rz [4] = '{REG_CTRL, REG_ACC, REG_FLAGS, 10'h100};
    logic [INSTR_W-1:0] cw [3];
    int                 er, ei;
    cw = '{{OP_ADD_ACC_TO_REG, 8'h05}, {OP_SKIP_IF_BIT_LOW, 10'h005}, {OP_SET_REG_BIT, 10'h005}};
    void'($urandom(13623));
    for (int i = 0; i < 16; i++) rom[i] = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // reset values survive a write with lane 0 off and a write to an unmapped place
    avs_byteenable <= 4'hE;
    bus(1'b1, REG_ACC, 32'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b1, 10'h100, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, rz[i], 32'h0);
      check(q, 32'h0);
    end
    for (int t = 0; t < 4; t++) begin
      acc_m = (t == 0) ? 8'h17 : 8'($urandom);
      bus(1'b1, REG_ACC, {24'h0, acc_m});
      for (int f = 0; f < 128; f++) begin
        fm[f] = (t == 0 && f == 5) ? 8'hC2 : 8'($urandom);
        bus(1'b1, REG_FILE_BASE + 10'(4 * f), {24'h0, fm[f]});
      end
      // round 0 opens with an add into the accumulator, then a taken skip over a set-bit word
      for (int i = 0; i < 16; i++) rom[i] <= (t == 0 && i < 3) ? cw[i] : rnd_word();
      nret = 0;
      nidle = 0;
      go <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h1);
      for (int k = 0; k < 300 && nret + nidle < 16; k++) @(posedge core_clk);
      bus(1'b1, REG_CTRL, 32'h0);
      go <= 1'b0;
      model(er, ei);
      check(32'(nret), 32'(er));
      check(32'(nidle), 32'(ei));
      bus(1'b0, REG_ACC, 32'h0);
      check(q, {24'h0, acc_m});
      bus(1'b0, REG_FLAGS, 32'h0);
      check(q, {29'h0, flg_m});
      // run is off here, so only the armed skip may show in the status word
      bus(1'b0, REG_EXEC_STAT, 32'h0);
      check(q, {31'h0, skip_m});
      for (int f = 0; f < 128; f++) begin
        bus(1'b0, REG_FILE_BASE + 10'(4 * f), 32'h0);
        check(q, {24'h0, fm[f]});
      end
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule
